/* core/hvw_pkg.sv */
// Constants, register map and field layout of the high-voltage wake input logic.
// Assumes a 40 MHz internal oscillator clock and an AXI4-Lite register bus.
package hvw_pkg;
    localparam int unsigned HVW_NWAKE = 3;
    // Input 1 can serve as the high-side sync input, input 2 is the supply-ratio input
    localparam int unsigned HVW_SYNC_IDX = 1;
    localparam int unsigned HVW_SUPPLY_IDX = 2;

    // Register byte offsets
    localparam logic [7:0] HVW_OFS_WAKE_CONTROL = 8'h00;
    localparam logic [7:0] HVW_OFS_WAKE_EVENT_STATUS = 8'h04;
    localparam logic [7:0] HVW_OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] HVW_OFS_WAKE_LEVEL_STATUS = 8'h0c;

    // Per-input control byte: input i occupies bits [8*i+7 : 8*i]
    localparam int unsigned HVW_CTRL_STRIDE = 8;
    localparam int unsigned HVW_POS_ENABLE = 0;
    localparam int unsigned HVW_POS_CYCLIC = 2;
    localparam int unsigned HVW_POS_PULL_SELECT_LO = 3;
    localparam int unsigned HVW_POS_PULL_SELECT_HI = 4;
    localparam int unsigned HVW_POS_FILTER = 5;

    localparam logic [23:0] HVW_RST_WAKE_CONTROL = 24'h000000;
    localparam logic [2:0] HVW_RST_MASK = 3'h0;

    // Wake enable selector codes
    localparam logic [1:0] HVW_EN_OFF = 2'h0;
    localparam logic [1:0] HVW_EN_SYNC = 2'h2;

    // Pull select codes
    localparam logic [1:0] HVW_PULL_NONE = 2'h0;
    localparam logic [1:0] HVW_PULL_DOWN = 2'h1;
    localparam logic [1:0] HVW_PULL_UP = 2'h2;
    localparam logic [1:0] HVW_PULL_AUTO = 2'h3;

    // Filter times
    localparam int unsigned HVW_CLK_PERIOD_PS = 25000;
    localparam int unsigned HVW_FILT1_US = 16;
    localparam int unsigned HVW_FILT2_US = 64;
    localparam logic [11:0] HVW_FILT1_CYC =
        12'((HVW_FILT1_US * 1000000 + HVW_CLK_PERIOD_PS - 1) / HVW_CLK_PERIOD_PS);
    localparam logic [11:0] HVW_FILT2_CYC =
        12'((HVW_FILT2_US * 1000000 + HVW_CLK_PERIOD_PS - 1) / HVW_CLK_PERIOD_PS);

    localparam logic [1:0] HVW_RESP_OKAY = 2'h0;
    localparam logic [1:0] HVW_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        HVW_MODE_INIT = 3'b000,
        HVW_MODE_NORMAL = 3'b001,
        HVW_MODE_STOP = 3'b010,
        HVW_MODE_SLEEP = 3'b011,
        HVW_MODE_FAILSAFE = 3'b100
    } hvw_mode_t;
endpackage

/* core/hvw_wake_input.sv */
// High-voltage wake input logic: edge detection, filtering, static and cyclic
// sensing, event latching, level readout, pull control and sync selection.
// Assumes wake comparator outputs arrive asynchronously, while the device mode and
// high-side on-time signals come from logic on the same clock.
//
// Operation
// RULE1: Both rising and falling edges on each wake input are wake events.
// RULE2: Events raise the interrupt in Normal/Stop, wake the device in Sleep/Fail-Safe.
// RULE3: Software picks static (always) or cyclic (limited window) sensing per input.
// RULE4: Crossing starts filter; crossing back before expiry discards the pulse.
// RULE5: Each input's wake capability is individually enabled; disabled gives no wake.
// RULE6: Accepted events latch in a status flag readable at any time.
// RULE7: Live pin level readable in Normal, Stop and Init modes.
// RULE8: Under cyclic sensing the level readout shows the last sampled level.
// RULE9: Two-bit pull select: none default, pull-down, pull-up, automatic.
// RULE10: Automatic pull follows detected level: high gives pull-up, low pull-down.
// RULE11: Supply-ratio input has fixed pull-up and ignores its pull select.
// RULE12: Per-input filter select sets filter time for static and cyclic sensing.
// RULE13: Init to Normal with static sensing flags an input already high.
// RULE14: Cyclic sensing samples during high-side on-time; level change makes event.
// RULE15: Sync-configured input gives no level readout and no wake detection.
// RULE16: In cyclic sensing the sync input may be driven externally to time high-side.
// RULE17: Enable selector 10 selects sync, ignoring the bank and disabling wake.
// RULE18: Software switches the sync-capable input off before selecting sync.
// RULE19: Filter counter on oscillator clock restarts per crossing, accepts at length.
`timescale 1ns/100ps
`default_nettype none

module hvw_wake_input
    import hvw_pkg::*;
(
    input wire logic clk_i,                          // 40 MHz oscillator clock
    input wire logic reset_i,                        // Synchronous reset, active high
    input wire logic [HVW_NWAKE-1:0] wake_pin_i,     // Wake comparator outputs, async
    input wire logic [HVW_NWAKE-1:0] hs_on_i,        // High-side on-time per input
    input wire hvw_pkg::hvw_mode_t dev_mode_i,       // Device operating mode
    output logic [HVW_NWAKE-1:0] pull_up_en_o,       // Pull-up current source enables
    output logic [HVW_NWAKE-1:0] pull_down_en_o,     // Pull-down current source enables
    output logic sync_active_o,                      // Sync-capable input acts as sync
    output logic sync_o,                             // Synchronised sync level to high side
    output logic wake_req_o,                         // One-cycle wake request from low power
    output logic irq_o,                              // Level interrupt
    input wire logic [7:0] s_axi_awaddr,             // Write address
    input wire logic s_axi_awvalid,                  // Write address valid
    output logic s_axi_awready,                      // Write address ready
    input wire logic [31:0] s_axi_wdata,             // Write data
    input wire logic [3:0] s_axi_wstrb,              // Write strobes
    input wire logic s_axi_wvalid,                   // Write data valid
    output logic s_axi_wready,                       // Write data ready
    output logic [1:0] s_axi_bresp,                  // Write response
    output logic s_axi_bvalid,                       // Write response valid
    input wire logic s_axi_bready,                   // Write response ready
    input wire logic [7:0] s_axi_araddr,             // Read address
    input wire logic s_axi_arvalid,                  // Read address valid
    output logic s_axi_arready,                      // Read address ready
    output logic [31:0] s_axi_rdata,                 // Read data
    output logic [1:0] s_axi_rresp,                  // Read response
    output logic s_axi_rvalid,                       // Read data valid
    input wire logic s_axi_rready                    // Read data ready
);
    import hvw_pkg::*;

    typedef struct packed {
        logic [HVW_NWAKE-1:0] meta;
        logic [HVW_NWAKE-1:0] pin;
        logic [HVW_NWAKE-1:0] prev_pin;
        logic [HVW_NWAKE-1:0] stable;
        logic [HVW_NWAKE-1:0] sample;
        logic [HVW_NWAKE-1:0][11:0] cnt;
        logic [HVW_NWAKE-1:0] busy;
        logic [23:0] ctrl;
        logic [HVW_NWAKE-1:0] status;
        logic [HVW_NWAKE-1:0] mask;
        hvw_mode_t prev_mode;
        logic wake_req;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } hvw_state_t;

    hvw_state_t s_r;
    hvw_state_t s_nxt;

    logic [HVW_NWAKE-1:0] en;
    logic [HVW_NWAKE-1:0] cyclic;
    logic [HVW_NWAKE-1:0] is_sync;
    logic [HVW_NWAKE-1:0] level_view;
    logic [HVW_NWAKE-1:0] event_set;
    logic [HVW_NWAKE-1:0] status_clr;
    logic readout_mode;
    logic active_mode;
    logic lowpwr_mode;
    logic do_write;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic rd_ok;

    always_comb
    begin
        s_nxt = s_r;
        // Two flops before any logic looks at the pins
        s_nxt.meta = wake_pin_i;
        s_nxt.pin = s_r.meta;
        s_nxt.prev_pin = s_r.pin;
        s_nxt.prev_mode = dev_mode_i;

        active_mode = (dev_mode_i == HVW_MODE_NORMAL) || (dev_mode_i == HVW_MODE_STOP);
        lowpwr_mode = (dev_mode_i == HVW_MODE_SLEEP) || (dev_mode_i == HVW_MODE_FAILSAFE);
        readout_mode = active_mode || (dev_mode_i == HVW_MODE_INIT);

        event_set = '0;
        for (int i = 0; i < HVW_NWAKE; i++)
        begin
            // RULE17 sync select
            is_sync[i] = (i == HVW_SYNC_IDX) &&
                (s_r.ctrl[i*HVW_CTRL_STRIDE+HVW_POS_ENABLE +: 2] == HVW_EN_SYNC);
            // RULE5 per-input enable
            en[i] = (s_r.ctrl[i*HVW_CTRL_STRIDE+HVW_POS_ENABLE +: 2] != HVW_EN_OFF) &&
                !is_sync[i];
            // RULE3 sensing mode
            cyclic[i] = s_r.ctrl[i*HVW_CTRL_STRIDE+HVW_POS_CYCLIC];

            // RULE19 filter counter restarts on every crossing
            if (s_r.pin[i] != s_r.prev_pin[i])
            begin
                s_nxt.cnt[i] = 12'h001;
                s_nxt.busy[i] = 1'b1;
            end
            // RULE14 cyclic filter only runs during high-side on-time
            else if (cyclic[i] && !hs_on_i[i])
            begin
                s_nxt.cnt[i] = '0;
                s_nxt.busy[i] = 1'b0;
            end
            else if (s_r.busy[i])
            begin
                s_nxt.cnt[i] = s_r.cnt[i] + 12'h001;
                // RULE12 per-input filter length
                // RULE4 accept only if no crossing back before expiry
                if (s_r.cnt[i] >= (s_r.ctrl[i*HVW_CTRL_STRIDE+HVW_POS_FILTER] ?
                                   HVW_FILT2_CYC : HVW_FILT1_CYC))
                begin
                    s_nxt.busy[i] = 1'b0;
                    s_nxt.cnt[i] = '0;
                    s_nxt.stable[i] = s_r.pin[i];
                    // RULE1 either direction counts
                    if (!cyclic[i] && s_r.pin[i] != s_r.stable[i])
                    begin
                        event_set[i] = en[i];
                    end
                    // RULE14 cyclic sample differs from last sample
                    if (cyclic[i])
                    begin
                        s_nxt.sample[i] = s_r.pin[i];
                        event_set[i] = en[i] && (s_r.pin[i] != s_r.sample[i]);
                    end
                end
            end
            else if (cyclic[i] && hs_on_i[i] && (s_r.pin[i] != s_r.sample[i]))
            begin
                // A level that moved since the last sample must survive the filter first
                s_nxt.cnt[i] = 12'h001;
                s_nxt.busy[i] = 1'b1;
            end

            // RULE13 already-high input flagged on Init to Normal in static sensing
            if (s_r.prev_mode == HVW_MODE_INIT && dev_mode_i == HVW_MODE_NORMAL &&
                !cyclic[i] && en[i] && s_r.pin[i])
            begin
                event_set[i] = 1'b1;
            end

            // RULE8 cyclic readout is the sample
            // RULE15 sync input reads zero
            level_view[i] = is_sync[i] ? 1'b0 : (cyclic[i] ? s_r.sample[i] : s_r.pin[i]);

            // RULE11 supply-ratio input fixed pull-up
            if (i == HVW_SUPPLY_IDX)
            begin
                pull_up_en_o[i] = 1'b1;
                pull_down_en_o[i] = 1'b0;
            end
            else if (is_sync[i])
            begin
                pull_up_en_o[i] = 1'b0;
                pull_down_en_o[i] = 1'b0;
            end
            else
            begin
                // RULE9 pull select decode
                unique case (s_r.ctrl[i*HVW_CTRL_STRIDE+HVW_POS_PULL_SELECT_LO +: 2])
                    HVW_PULL_NONE:
                    begin
                        pull_up_en_o[i] = 1'b0;
                        pull_down_en_o[i] = 1'b0;
                    end
                    HVW_PULL_DOWN:
                    begin
                        pull_up_en_o[i] = 1'b0;
                        pull_down_en_o[i] = 1'b1;
                    end
                    HVW_PULL_UP:
                    begin
                        pull_up_en_o[i] = 1'b1;
                        pull_down_en_o[i] = 1'b0;
                    end
                    HVW_PULL_AUTO:
                    begin
                        // RULE10 pull follows detected level
                        pull_up_en_o[i] = s_r.stable[i];
                        pull_down_en_o[i] = !s_r.stable[i];
                    end
                endcase
            end
        end

        // RULE2 low-power modes get a wake request instead of the interrupt
        s_nxt.wake_req = lowpwr_mode && (|event_set);

        // Register write path: address and data taken in either order
        s_axi_awready = !s_r.aw_got && !s_r.bvalid;
        s_axi_wready = !s_r.w_got && !s_r.bvalid;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{s_r.wstrb[b]}};
        end
        status_clr = '0;
        if (do_write)
        begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = HVW_RESP_OKAY;
            unique case ({s_r.awaddr[7:2], 2'b00})
                HVW_OFS_WAKE_CONTROL:
                    // RULE18 software switches off before sync; no sequencing enforced here
                    s_nxt.ctrl = (s_r.ctrl & ~wmask[23:0]) | (s_r.wdata[23:0] & wmask[23:0]);
                HVW_OFS_WAKE_EVENT_STATUS:
                    status_clr = s_r.wdata[HVW_NWAKE-1:0] & wmask[HVW_NWAKE-1:0];
                HVW_OFS_IRQ_MASK:
                    s_nxt.mask = (s_r.mask & ~wmask[HVW_NWAKE-1:0]) |
                        (s_r.wdata[HVW_NWAKE-1:0] & wmask[HVW_NWAKE-1:0]);
                HVW_OFS_WAKE_LEVEL_STATUS:
                    s_nxt.bresp = HVW_RESP_OKAY;
                default:
                    s_nxt.bresp = HVW_RESP_SLVERR;
            endcase
        end
        if (s_r.bvalid && s_axi_bready)
        begin
            s_nxt.bvalid = 1'b0;
        end

        // RULE6 sticky flag; a new event wins over a clear in the same cycle
        s_nxt.status = (s_r.status & ~status_clr) | event_set;

        // Register read path
        rd_ok = 1'b1;
        rd_val = '0;
        unique case ({s_axi_araddr[7:2], 2'b00})
            HVW_OFS_WAKE_CONTROL:
                rd_val = {8'h00, s_r.ctrl};
            HVW_OFS_WAKE_EVENT_STATUS:
                rd_val = {29'h0, s_r.status};
            HVW_OFS_IRQ_MASK:
                rd_val = {29'h0, s_r.mask};
            HVW_OFS_WAKE_LEVEL_STATUS:
                // RULE7 level readable only in Normal, Stop, Init
                rd_val = {29'h0, readout_mode ? level_view : 3'h0};
            default:
                rd_ok = 1'b0;
        endcase
        s_axi_arready = !s_r.rvalid;
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_val;
            s_nxt.rresp = rd_ok ? HVW_RESP_OKAY : HVW_RESP_SLVERR;
        end
        else if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end

        // RULE2 interrupt only in Normal and Stop
        irq_o = active_mode && |(s_r.status & s_r.mask);
        // RULE16 sync level forwarded to the high-side timing
        sync_active_o = is_sync[HVW_SYNC_IDX];
        sync_o = is_sync[HVW_SYNC_IDX] && s_r.pin[HVW_SYNC_IDX];
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_r <= '0;
            s_r.ctrl <= HVW_RST_WAKE_CONTROL;
            s_r.mask <= HVW_RST_MASK;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign wake_req_o = s_r.wake_req;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
endmodule

`default_nettype wire

/* verif/hvw_wake_props.sv */
// Checker for the wake input block: pulls, sync gating, irq, wake and bus timing.
// Sees only the top-level ports; bound to the design below.
`timescale 1ns/100ps
`default_nettype none
module hvw_wake_props
    import hvw_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Sync reset
    input wire hvw_pkg::hvw_mode_t dev_mode_i, // Mode
    input wire logic [HVW_NWAKE-1:0] pull_up_en_o, // Pull-ups
    input wire logic [HVW_NWAKE-1:0] pull_down_en_o, // Pull-downs
    input wire logic sync_active_o, // Sync selected
    input wire logic sync_o, // Sync level
    input wire logic wake_req_o, // Wake pulse
    input wire logic irq_o, // Interrupt
    input wire logic s_axi_awvalid, // Bus
    input wire logic s_axi_awready, // Bus
    input wire logic s_axi_wvalid, // Bus
    input wire logic s_axi_wready, // Bus
    input wire logic s_axi_bvalid, // Bus
    input wire logic s_axi_bready, // Bus
    input wire logic s_axi_arvalid, // Bus
    input wire logic s_axi_arready, // Bus
    input wire logic [31:0] s_axi_rdata, // Bus
    input wire logic s_axi_rvalid, // Bus
    input wire logic s_axi_rready // Bus
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_stalled;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    AST_SUPPLY_PULL: assert property (pull_up_en_o[2] && !pull_down_en_o[2])
        else $error("supply input pull wrong");
    AST_PULL_EXCL: assert property ((pull_up_en_o & pull_down_en_o) == 3'h0)
        else $error("pull-up and pull-down both on");
    AST_SYNC_GATE: assert property (!sync_active_o |-> !sync_o)
        else $error("sync output without sync mode");
    AST_IRQ_MODE: assert property (irq_o |-> dev_mode_i inside {HVW_MODE_NORMAL, HVW_MODE_STOP})
        else $error("interrupt outside active modes");
    AST_WAKE_MODE: assert property (wake_req_o |-> dev_mode_i inside {HVW_MODE_SLEEP, HVW_MODE_FAILSAFE})
        else $error("wake request outside low-power modes");
    AST_WAKE_PULSE: assert property (wake_req_o |=> !wake_req_o)
        else $error("wake request longer than one cycle");
    AST_WR_RESP: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_RSP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_HOLD: assert property (rd_stalled |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule
bind hvw_wake_input hvw_wake_props u_props (.clk_i, .reset_i, .dev_mode_i, .pull_up_en_o,
    .pull_down_en_o, .sync_active_o, .sync_o, .wake_req_o, .irq_o, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* verif/hvw_switch_model.sv */
// Wake switch model: drives the comparator level of each wake input.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module hvw_switch_model
    import hvw_pkg::*;
(
    input wire logic clk_i, // Times pulses
    output logic [HVW_NWAKE-1:0] wake_pin_o // Switch levels
);
    initial wake_pin_o = '0;
    task automatic set(input int i, input logic v);
        wake_pin_o[i] <= v;
    endtask
    task automatic glitch(input int i, input int n);
        wake_pin_o[i] <= !wake_pin_o[i];
        repeat (n) @(posedge clk_i);
        wake_pin_o[i] <= !wake_pin_o[i];
    endtask
endmodule
`default_nettype wire

/* verif/test_hvw_wake_input.sv */
// Self-checking bench for the wake input block, with a wake switch model.
// Assumes the AXI4-Lite slave timing of the design and a 25 ns clock.
`timescale 1ns/100ps
`default_nettype none
module test_hvw_wake_input;
    import hvw_pkg::*;
    logic clk_i, reset_i, sync_act, sync_o, wake_req, irq;
    logic [2:0] hs_on, pu, pd, pins;
    hvw_mode_t mode;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int failures, total_checks, wakes, stat_m, up, dn;
    hvw_wake_input u_dut (.clk_i(clk_i), .reset_i(reset_i), .wake_pin_i(pins), .hs_on_i(hs_on),
        .dev_mode_i(mode), .pull_up_en_o(pu), .pull_down_en_o(pd), .sync_active_o(sync_act),
        .sync_o(sync_o), .wake_req_o(wake_req), .irq_o(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    hvw_switch_model u_src (.clk_i(clk_i), .wake_pin_o(pins));
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (wake_req === 1'b1) wakes++;
    task automatic conclude();
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Both channels offered together; each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            // Late ready lets the response stall once
            if (n == 3) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 60);
        rsp = bresp;
        bready <= 1'b0;
        if (n >= 60) failures++;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
            if (arready) arvalid <= 1'b0;
            // Late ready lets the read data stall once
            if (n == 2) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 60);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 60) failures++;
    endtask
    task automatic chk_stat();
        rd_reg(HVW_OFS_WAKE_EVENT_STATUS);
        chk(rd, 32'(stat_m));
    endtask
    task automatic clr();
        wr(HVW_OFS_WAKE_EVENT_STATUS, 32'h7);
        stat_m = 0;
    endtask
    initial
    begin
        // Bounded well above the roughly 13k cycles the tests need
        cyc(60000);
        failures++;
        conclude();
    end
    initial
    begin
        {reset_i, hs_on, awaddr, araddr, wdata} = {1'b1, 51'h0};
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {failures, total_checks, wakes, stat_m} = {32'h0, 32'h0, 32'h0, 32'h0};
        wstrb = 4'hf;
        mode = HVW_MODE_INIT;
        void'($urandom(32'h8097));
        cyc(4);
        reset_i <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd_reg(8'(4 * i));
            chk(rd, 32'h0);
        end
        chk(32'({pu, pd}), 32'h20);
        rd_reg(8'h10);
        chk(32'(rsp), 32'(HVW_RESP_SLVERR));
        for (int p = 0; p < 8; p++)
        begin
            wr(HVW_OFS_WAKE_CONTROL, {8'h0, 8'((p % 4) << 3), 8'h0, 8'((p % 4) << 3)});
            u_src.set(0, p / 4);
            // Automatic pull follows the filtered level, so let the filter settle
            cyc((p % 4 == 3) ? 700 : 6);
            up = (p % 4 == 2) || (p % 4 == 3 && p / 4 == 1);
            dn = (p % 4 == 1) || (p % 4 == 3 && p / 4 == 0);
            chk(32'({pu, pd}), 32'({1'b1, 1'b0, up[0], 2'h0, dn[0]}));
        end
        u_src.set(0, 0);
        cyc(700);
        wr(HVW_OFS_IRQ_MASK, 32'h7);
        wr(HVW_OFS_WAKE_CONTROL, 32'h01);
        mode <= HVW_MODE_NORMAL;
        cyc(700);
        u_src.glitch(0, 20 + $urandom % 600);
        cyc(700);
        chk_stat();
        u_src.set(0, 1);
        cyc(600);
        chk_stat();
        cyc(60);
        stat_m = 1;
        chk_stat();
        chk(32'(irq), 32'h1);
        wr(HVW_OFS_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        wr(HVW_OFS_IRQ_MASK, 32'h7);
        clr();
        chk_stat();
        wr(HVW_OFS_WAKE_CONTROL, 32'h21);
        u_src.set(0, 0);
        cyc(2500);
        chk_stat();
        cyc(100);
        stat_m = 1;
        chk_stat();
        clr();
        wr(HVW_OFS_WAKE_CONTROL, 32'h0);
        u_src.glitch(0, 800);
        cyc(800);
        chk_stat();
        u_src.set(2, 1);
        cyc(700);
        clr();
        rd_reg(HVW_OFS_WAKE_LEVEL_STATUS);
        chk(rd, 32'h4);
        u_src.set(2, 0);
        wr(HVW_OFS_WAKE_CONTROL, 32'h01);
        mode <= HVW_MODE_SLEEP;
        wakes = 0;
        u_src.set(0, 1);
        cyc(700);
        chk(32'(wakes), 32'h1);
        chk(32'(irq), 32'h0);
        stat_m = 1;
        chk_stat();
        clr();
        mode <= HVW_MODE_INIT;
        cyc(4);
        mode <= HVW_MODE_NORMAL;
        cyc(4);
        stat_m = 1;
        chk_stat();
        clr();
        wr(HVW_OFS_WAKE_CONTROL, 32'h3e01);
        u_src.set(1, 1);
        cyc(700);
        chk(32'({sync_act, sync_o}), 32'h3);
        rd_reg(HVW_OFS_WAKE_LEVEL_STATUS);
        chk(rd, 32'h1);
        chk_stat();
        u_src.set(1, 0);
        wr(HVW_OFS_WAKE_CONTROL, 32'h05);
        hs_on <= 3'h1;
        cyc(700);
        hs_on <= 3'h0;
        clr();
        u_src.set(0, 0);
        cyc(700);
        chk_stat();
        rd_reg(HVW_OFS_WAKE_LEVEL_STATUS);
        chk(rd, 32'h1);
        hs_on <= 3'h1;
        cyc(700);
        hs_on <= 3'h0;
        stat_m = 1;
        chk_stat();
        conclude();
    end
endmodule
`default_nettype wire
